//--- rtl/sps_regs.vh
// What this block does
// - index write with select low, data follows high
// - scroll start value is the first line address
// - scroll count value means lines minus one
// - scroll step is the offset, zero stops scrolling
// - zero step disables scroll with no ordering
// - start plus count reaching 176 means no scroll
// - step above count means no scroll
// - partial mode disables the scroll function
// - partial start value is first area line
// - partial count is lines, no minus one
// - stand-by only by writing its bit to one
// - stand-by forces low level, finishes current frame
// - then all gates on with amplifiers off, then oscillator stop
// - control register one bit layout, zero inactive
// - power register one enable bit layout
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// register indices
`define SPS_IDX_CTRL_ONE 7'h00
`define SPS_IDX_SCROLL_FIRST 7'h0f
`define SPS_IDX_SCROLL_WINDOW 7'h10
`define SPS_IDX_SCROLL_STEPS 7'h11
`define SPS_IDX_PART_ONE_FIRST 7'h14
`define SPS_IDX_PART_TWO_FIRST 7'h15
`define SPS_IDX_PART_ONE_TOTAL 7'h16
`define SPS_IDX_PART_TWO_TOTAL 7'h17
`define SPS_IDX_POWER_ONE 7'h19

// control register one fields
`define SPS_CTRL_ALL_ONES 7
`define SPS_CTRL_ALL_ZEROS 6
`define SPS_CTRL_USAGE 5
`define SPS_CTRL_PARTIAL 4
`define SPS_CTRL_STANDBY 3
`define SPS_CTRL_COLOUR 2
`define SPS_CTRL_POWER_MODE 1
`define SPS_CTRL_RSVD_MASK 8'hfe

// power supply control register one fields
`define SPS_PWR_GATE_REG 2
`define SPS_PWR_POWER_REG 1
`define SPS_PWR_DCDC 0

// reset value and panel geometry
`define SPS_RESET_VAL 8'h00
`define SPS_PANEL_LINES 176
`define SPS_LINE_CYCLES 64
`define SPS_DISCHARGE_CYCLES 256

`endif

//--- rtl/sps_regmem.v
`timescale 1ns/1ps
// register image for read-back; read data leave through a flop
module sps_regmem #(
  parameter AW = 7,
  parameter DW = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  // read port
  input wire [AW-1:0] i_raddr,
  output wire [DW-1:0] o_rdata
);
  localparam DEPTH = 1 << AW;
  reg [DW-1:0] mem_q [0:DEPTH-1];
  reg [DW-1:0] rdata_q;
  integer k;

  // every entry resets to zero, so reads of unwritten indices are defined
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_q[k] <= {DW{1'b0}};
      end
      rdata_q <= {DW{1'b0}};
    end else begin
      if (i_we) begin
        mem_q[i_waddr] <= i_wdata;
      end
      rdata_q <= mem_q[i_raddr];
    end
  end

  assign o_rdata = rdata_q;
endmodule // sps_regmem

//--- rtl/sps_ctrl.v
`timescale 1ns/1ps
`include "sps_regs.vh"

module sps_ctrl #(
  parameter LINES = `SPS_PANEL_LINES,
  parameter LINE_CYCLES = `SPS_LINE_CYCLES,
  parameter DISCHARGE_CYCLES = `SPS_DISCHARGE_CYCLES
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // host register port
  input wire i_register_select,
  input wire i_wr_strobe,
  input wire i_rd_strobe,
  input wire [15:0] i_data,
  output wire [7:0] o_rd_data,
  output wire o_rd_valid,
  // scan outputs
  output wire [7:0] o_scan_line,
  output wire [7:0] o_fetch_line,
  output wire o_line_shown,
  output wire o_frame_start,
  output wire o_scroll_active,
  // output stage control
  output wire o_force_ones,
  output wire o_force_zeros,
  output wire o_force_vss,
  output wire o_all_gates_on,
  output wire o_amp_enable,
  output wire o_osc_enable,
  output wire o_colour_reduced,
  output wire o_low_power,
  output wire o_standby_done,
  // companion supply enables
  output wire o_gate_reg_en,
  output wire o_power_reg_en,
  output wire o_dcdc_en
);

  ////////////////////////////////////////////////////////////////////////////
  // constants
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_FINISH = 2'd1;
  localparam [1:0] ST_DISCH = 2'd2;
  localparam [1:0] ST_STOP = 2'd3;
  localparam [8:0] LINES_W = LINES[8:0];
  localparam [7:0] LAST_LINE = LINES_W[7:0] - 8'h01;
  localparam [15:0] LAST_CYC = LINE_CYCLES[15:0] - 16'h0001;
  localparam [15:0] LAST_DISCH = DISCHARGE_CYCLES[15:0] - 16'h0001;
  // true when line y falls in [first, first+total)
  function in_area;
    input [7:0] y;
    input [7:0] first;
    input [7:0] total;
    reg [8:0] stop;
    begin
      stop = {1'b0, first} + {1'b0, total};
      in_area = (total != 8'h00) && (y >= first) && ({1'b0, y} < stop);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register port
  reg [6:0] index_q;
  reg [7:0] ctrl_q;
  reg [7:0] scroll_first_line_q;
  reg [7:0] scroll_window_lines_q;
  reg [7:0] scroll_offset_steps_q;
  reg [7:0] partial_one_first_line_q;
  reg [7:0] partial_two_first_line_q;
  reg [7:0] partial_one_line_total_q;
  reg [7:0] partial_two_line_total_q;
  reg [7:0] power_q;
  reg standby_req_q;
  wire data_wr;
  wire [7:0] wr_byte;
  wire [7:0] mem_rdata;
  assign data_wr = i_wr_strobe & i_register_select;
  assign wr_byte = i_data[7:0];

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      index_q <= 7'h00;
      ctrl_q <= `SPS_RESET_VAL;
      scroll_first_line_q <= `SPS_RESET_VAL;
      scroll_window_lines_q <= `SPS_RESET_VAL;
      scroll_offset_steps_q <= `SPS_RESET_VAL;
      partial_one_first_line_q <= `SPS_RESET_VAL;
      partial_two_first_line_q <= `SPS_RESET_VAL;
      partial_one_line_total_q <= `SPS_RESET_VAL;
      partial_two_line_total_q <= `SPS_RESET_VAL;
      power_q <= `SPS_RESET_VAL;
      standby_req_q <= 1'b0;
    end else begin
      standby_req_q <= 1'b0;
      if (i_wr_strobe && !i_register_select) begin
        index_q <= i_data[6:0];
      end
      if (data_wr) begin
        case (index_q)
          `SPS_IDX_CTRL_ONE: begin
            ctrl_q <= wr_byte & `SPS_CTRL_RSVD_MASK;
            standby_req_q <= wr_byte[`SPS_CTRL_STANDBY];
          end
          `SPS_IDX_SCROLL_FIRST: begin
            scroll_first_line_q <= wr_byte;
          end
          `SPS_IDX_SCROLL_WINDOW: begin
            scroll_window_lines_q <= wr_byte;
          end
          `SPS_IDX_SCROLL_STEPS: begin
            scroll_offset_steps_q <= wr_byte;
          end
          `SPS_IDX_PART_ONE_FIRST: begin
            partial_one_first_line_q <= wr_byte;
          end
          `SPS_IDX_PART_TWO_FIRST: begin
            partial_two_first_line_q <= wr_byte;
          end
          `SPS_IDX_PART_ONE_TOTAL: begin
            partial_one_line_total_q <= wr_byte;
          end
          `SPS_IDX_PART_TWO_TOTAL: begin
            partial_two_line_total_q <= wr_byte;
          end
          `SPS_IDX_POWER_ONE: begin
            power_q <= wr_byte;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // full image of the index space for read-back
  sps_regmem #(
    .AW(7),
    .DW(8)
  ) u_regmem (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_we(data_wr),
    .i_waddr(index_q),
    .i_wdata(wr_byte),
    .i_raddr(index_q),
    .o_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path: strobe, memory flop, output flop
  reg rd_p1_q;
  reg rd_rs_q;
  reg [6:0] rd_idx_q;
  reg [7:0] rd_data_q;
  reg rd_valid_q;
  reg [1:0] state_q;
  reg scroll_ok_q;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_p1_q <= 1'b0;
      rd_rs_q <= 1'b0;
      rd_idx_q <= 7'h00;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_p1_q <= i_rd_strobe;
      rd_rs_q <= i_register_select;
      rd_idx_q <= index_q;
      rd_valid_q <= rd_p1_q;
      if (rd_p1_q) begin
        if (!rd_rs_q) begin
          // status view: scroll validity and stand-by progress
          rd_data_q <= {5'h00, scroll_ok_q, state_q};
        end else if (rd_idx_q == `SPS_IDX_CTRL_ONE) begin
          rd_data_q <= mem_rdata & `SPS_CTRL_RSVD_MASK;
        end else begin
          rd_data_q <= mem_rdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal timing; the counters clear to zero while the oscillator is stopped
  reg [15:0] cyc_q;
  reg [7:0] line_q;
  reg [15:0] disch_q;
  reg osc_en_q;
  wire line_tick;
  wire frame_end;
  assign line_tick = osc_en_q && (cyc_q == LAST_CYC);
  assign frame_end = line_tick && (line_q == LAST_LINE);
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      cyc_q <= 16'h0000;
      line_q <= 8'h00;
    end else if (state_q == ST_STOP) begin
      // restart scanning from the top after wake-up
      cyc_q <= 16'h0000;
      line_q <= 8'h00;
    end else if (osc_en_q) begin
      if (line_tick) begin
        cyc_q <= 16'h0000;
        line_q <= frame_end ? 8'h00 : line_q + 8'h01;
      end else begin
        cyc_q <= cyc_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stand-by sequencer
  reg [1:0] state_d;
  wire standby_bit;
  assign standby_bit = ctrl_q[`SPS_CTRL_STANDBY];

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (standby_req_q) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (frame_end) begin
          state_d = ST_DISCH;
        end
      end
      ST_DISCH: begin
        if (disch_q == LAST_DISCH) begin
          // a release that came in early resumes scanning when discharge ends, without a stop
          state_d = standby_bit ? ST_STOP : ST_RUN;
        end
      end
      ST_STOP: begin
        if (!standby_bit) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= ST_RUN;
      disch_q <= 16'h0000;
      osc_en_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q == ST_DISCH) begin
        disch_q <= disch_q + 16'h0001;
      end else begin
        disch_q <= 16'h0000;
      end
      osc_en_q <= (state_d != ST_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scroll and partial decode for the current line
  reg scroll_ok;
  reg [8:0] scroll_sum;
  reg [8:0] scroll_len;
  reg [8:0] scroll_off;
  reg [7:0] fetch_d;
  reg in_window;
  reg part_two_ok;
  reg shown_d;
  wire partial_mode;
  assign partial_mode = ctrl_q[`SPS_CTRL_PARTIAL];

  always @* begin
    scroll_sum = {1'b0, scroll_first_line_q} + {1'b0, scroll_window_lines_q};
    scroll_len = {1'b0, scroll_window_lines_q} + 9'h001;
    scroll_ok = (scroll_offset_steps_q != 8'h00) &&
                (scroll_sum < LINES_W) &&
                (scroll_offset_steps_q <= scroll_window_lines_q) &&
                !partial_mode;
    in_window = (line_q >= scroll_first_line_q) && ({1'b0, line_q} <= scroll_sum);
    scroll_off = {1'b0, line_q - scroll_first_line_q} + {1'b0, scroll_offset_steps_q};
    if (scroll_off >= scroll_len) begin
      scroll_off = scroll_off - scroll_len;
    end
    if (scroll_ok && in_window) begin
      fetch_d = scroll_first_line_q + scroll_off[7:0];
    end else begin
      fetch_d = line_q;
    end
    // second area only counts once the first is set and the two stay apart
    part_two_ok = (partial_one_line_total_q != 8'h00) &&
                  (partial_two_line_total_q != 8'h00) &&
                  (({1'b0, partial_two_first_line_q} >=
                    {1'b0, partial_one_first_line_q} + {1'b0, partial_one_line_total_q} +
                    9'h001) ||
                   ({1'b0, partial_one_first_line_q} >=
                    {1'b0, partial_two_first_line_q} + {1'b0, partial_two_line_total_q} +
                    9'h001));
    if (!partial_mode || (partial_one_line_total_q == 8'h00)) begin
      shown_d = 1'b1;
    end else begin
      shown_d = in_area(line_q, partial_one_first_line_q, partial_one_line_total_q) ||
                (part_two_ok &&
                 in_area(line_q, partial_two_first_line_q, partial_two_line_total_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output flops
  reg [7:0] scan_line_q;
  reg [7:0] fetch_line_q;
  reg shown_q;
  reg frame_start_q;
  reg force_vss_q;
  reg gates_on_q;
  reg amp_en_q;
  reg done_q;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      scan_line_q <= 8'h00;
      fetch_line_q <= 8'h00;
      shown_q <= 1'b1;
      frame_start_q <= 1'b0;
      scroll_ok_q <= 1'b0;
      force_vss_q <= 1'b0;
      gates_on_q <= 1'b0;
      amp_en_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      scan_line_q <= line_q;
      fetch_line_q <= fetch_d;
      shown_q <= shown_d;
      frame_start_q <= frame_end;
      scroll_ok_q <= scroll_ok;
      force_vss_q <= (state_d == ST_FINISH) || (state_d == ST_DISCH);
      gates_on_q <= (state_d == ST_DISCH);
      amp_en_q <= (state_d == ST_RUN) || (state_d == ST_FINISH);
      done_q <= (state_d == ST_STOP);
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_scan_line = scan_line_q;
  assign o_fetch_line = fetch_line_q;
  assign o_line_shown = shown_q;
  assign o_frame_start = frame_start_q;
  assign o_scroll_active = scroll_ok_q;
  assign o_force_ones = ctrl_q[`SPS_CTRL_ALL_ONES];
  assign o_force_zeros = ctrl_q[`SPS_CTRL_ALL_ZEROS];
  assign o_force_vss = force_vss_q;
  assign o_all_gates_on = gates_on_q;
  assign o_amp_enable = amp_en_q;
  assign o_osc_enable = osc_en_q;
  assign o_colour_reduced = ctrl_q[`SPS_CTRL_COLOUR];
  assign o_low_power = ctrl_q[`SPS_CTRL_POWER_MODE];
  assign o_standby_done = done_q;
  assign o_gate_reg_en = power_q[`SPS_PWR_GATE_REG];
  assign o_power_reg_en = power_q[`SPS_PWR_POWER_REG];
  assign o_dcdc_en = power_q[`SPS_PWR_DCDC];
endmodule // sps_ctrl

//--- verif/sps_host_model.sv
`timescale 1ns/1ps
// host side: strobes change at the falling edge, data inverted once released
module sps_host_model (
  // clock
  input wire i_ref_clk,
  // register port
  output reg o_register_select,
  output reg o_wr_strobe,
  output reg o_rd_strobe,
  output reg [15:0] o_data,
  input wire [7:0] i_rd_data,
  input wire i_rd_valid
);
  initial begin
    o_register_select = 1'b0;
    o_wr_strobe = 1'b0;
    o_rd_strobe = 1'b0;
    o_data = 16'h0000;
  end
  task strobe(input sel, input [15:0] d);
    @(negedge i_ref_clk);
    o_register_select = sel;
    o_data = d;
    o_wr_strobe = 1'b1;
    @(negedge i_ref_clk);
    o_wr_strobe = 1'b0;
    o_data = ~d;
  endtask
  // index first, then data with select high
  task wr_reg(input [6:0] idx, input [7:0] v);
    strobe(1'b0, {9'h1ff, idx});
    strobe(1'b1, {8'h5a, v});
  endtask
  task rd_reg(input [6:0] idx, output [7:0] v, output ok);
    reg early;
    strobe(1'b0, {9'h000, idx});
    @(negedge i_ref_clk);
    o_register_select = 1'b1;
    o_rd_strobe = 1'b1;
    @(negedge i_ref_clk);
    o_rd_strobe = 1'b0;
    early = i_rd_valid;
    @(negedge i_ref_clk);
    ok = (early === 1'b0) && (i_rd_valid === 1'b1);
    v = i_rd_data;
  endtask
  // settle waits shortened to a few tens of cycles
  task pwr(input [7:0] v);
    wr_reg(7'h19, v);
    repeat (20) @(negedge i_ref_clk);
  endtask
  // leave stand-by: converter, regulators, then the caller clears the bit
  task pwr_up;
    pwr(8'h01);
    pwr(8'h03);
    pwr(8'h07);
  endtask
  // after stand-by: regulators off, then the converter
  task pwr_down;
    pwr(8'h03);
    pwr(8'h01);
    pwr(8'h00);
  endtask
endmodule // sps_host_model

//--- verif/sps_ctrl_sva.sv
`timescale 1ns/1ps
module sps_ctrl_sva #(
  parameter LINES = 176,
  parameter LINE_CYCLES = 64,
  parameter DISCHARGE_CYCLES = 256
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // host port
  input wire i_register_select,
  input wire i_wr_strobe,
  input wire i_rd_strobe,
  input wire [15:0] i_data,
  input wire o_rd_valid,
  // status
  input wire o_scroll_active,
  input wire o_force_ones,
  input wire o_force_zeros,
  input wire o_force_vss,
  input wire o_all_gates_on,
  input wire o_amp_enable,
  input wire o_osc_enable,
  input wire o_colour_reduced,
  input wire o_low_power,
  input wire o_standby_done,
  input wire o_gate_reg_en,
  input wire o_power_reg_en,
  input wire o_dcdc_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of the control, scroll and power registers, so scroll validity can be judged
  wire wr_d = i_wr_strobe && i_register_select;
  reg [6:0] idx_q;
  reg [7:0] ctl_q, fst_q, win_q, stp_q, pwr_q;
  reg [15:0] gcnt_q;
  wire ok = (stp_q != 8'h00) && !ctl_q[4] && (stp_q <= win_q) &&
            (({1'b0, fst_q} + {1'b0, win_q}) < LINES);
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      idx_q <= 7'h00; ctl_q <= 8'h00; fst_q <= 8'h00; win_q <= 8'h00; stp_q <= 8'h00;
      gcnt_q <= 16'h0000;
      pwr_q <= 8'h00;
    end else begin
      if (i_wr_strobe && !i_register_select) idx_q <= i_data[6:0];
      if (wr_d && idx_q == 7'h00) ctl_q <= i_data[7:0];
      if (wr_d && idx_q == 7'h0f) fst_q <= i_data[7:0];
      if (wr_d && idx_q == 7'h10) win_q <= i_data[7:0];
      if (wr_d && idx_q == 7'h11) stp_q <= i_data[7:0];
      if (wr_d && idx_q == 7'h19) pwr_q <= i_data[7:0];
      gcnt_q <= o_all_gates_on ? gcnt_q + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_discharge_end;
    $fell(o_all_gates_on) ##0 (gcnt_q == DISCHARGE_CYCLES);
  endsequence
  sequence s_stopped;
    o_standby_done && !o_osc_enable && !o_amp_enable;
  endsequence
  a_rd_two_late: assert property (i_rd_strobe |-> ##2 o_rd_valid)
    else $error("read answer not two cycles late");
  a_rd_no_spurious: assert property (o_rd_valid |-> $past(i_rd_strobe, 2))
    else $error("read valid without request");
  a_ctrl_bits_map: assert property (wr_d && idx_q == 7'h00 |-> ##[1:2]
    (o_force_ones == ctl_q[7] && o_force_zeros == ctl_q[6] &&
     o_colour_reduced == ctl_q[2] && o_low_power == ctl_q[1]))
    else $error("control bits not on outputs");
  a_power_bits_map: assert property (wr_d && idx_q == 7'h19 |-> ##[1:2]
    ({o_gate_reg_en, o_power_reg_en, o_dcdc_en} == pwr_q[2:0]))
    else $error("power enables not on outputs");
  a_scroll_on_valid: assert property (ok [*4] |-> o_scroll_active)
    else $error("valid scroll setting not active");
  a_scroll_off_bad: assert property (!ok [*4] |-> !o_scroll_active)
    else $error("scroll active with invalid setting");
  a_vss_on_request: assert property (wr_d && idx_q == 7'h00 && i_data[3] &&
    o_osc_enable && !o_force_vss && !o_standby_done |-> ##[1:2] o_force_vss)
    else $error("stand-by request not taken");
  a_vss_needs_bit: assert property ($rose(o_force_vss) |-> ctl_q[3])
    else $error("stand-by without its bit");
  a_gates_after_vss: assert property ($rose(o_all_gates_on) |->
    $past(o_force_vss) && !o_amp_enable)
    else $error("discharge out of order");
  a_stop_after_dis: assert property (s_discharge_end ##0 ctl_q[3] |-> ##[0:1] s_stopped)
    else $error("no stop after discharge");
  a_wake_on_clear: assert property ($fell(o_standby_done) |-> ##[0:1]
    (o_osc_enable && o_amp_enable))
    else $error("no restart on release");
endmodule // sps_ctrl_sva
bind sps_ctrl sps_ctrl_sva #(.LINES(LINES), .LINE_CYCLES(LINE_CYCLES),
  .DISCHARGE_CYCLES(DISCHARGE_CYCLES)) sps_ctrl_sva_inst (.*);

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  reg i_ref_clk, i_rst;
  wire sel, wr, rd, rv, shown, fs, scr, ones, zeros, vss, gates, amp, osc, col, lowp, done;
  wire greg, preg, dcdc;
  wire [15:0] data;
  wire [7:0] rdat, line, fetch;
  integer n_mismatch, comparisons, k;
  reg [7:0] v;
  reg ok;
  sps_host_model sps_host_model_inst (.i_ref_clk(i_ref_clk), .o_register_select(sel),
    .o_wr_strobe(wr), .o_rd_strobe(rd), .o_data(data), .i_rd_data(rdat), .i_rd_valid(rv));
  // short line and discharge counts keep a frame at 704 cycles
  sps_ctrl #(.LINES(176), .LINE_CYCLES(4), .DISCHARGE_CYCLES(4)) sps_ctrl_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_register_select(sel), .i_wr_strobe(wr),
    .i_rd_strobe(rd), .i_data(data), .o_rd_data(rdat), .o_rd_valid(rv), .o_scan_line(line),
    .o_fetch_line(fetch), .o_line_shown(shown), .o_frame_start(fs), .o_scroll_active(scr),
    .o_force_ones(ones), .o_force_zeros(zeros), .o_force_vss(vss), .o_all_gates_on(gates),
    .o_amp_enable(amp), .o_osc_enable(osc), .o_colour_reduced(col), .o_low_power(lowp),
    .o_standby_done(done), .o_gate_reg_en(greg), .o_power_reg_en(preg), .o_dcdc_en(dcdc));
  ////////////////////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] exp, input string msg);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task wrap_up;
    $display("counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task flags(input [7:0] exp, input string msg);
    check({ones, zeros, vss, gates, amp, osc, done, shown}, exp, msg);
  endtask
  task rd_chk(input [6:0] idx, input [7:0] exp);
    sps_host_model_inst.rd_reg(idx, v, ok);
    check(v, exp, "read back");
    check({7'h00, ok}, 8'h01, "read timing");
  endtask
  task scroll(input [7:0] s, input [7:0] c, input [7:0] t, input e);
    sps_host_model_inst.wr_reg(7'h0f, s);
    sps_host_model_inst.wr_reg(7'h10, c);
    sps_host_model_inst.wr_reg(7'h11, t);
    repeat (4) @(negedge i_ref_clk);
    check({7'h00, scr}, {7'h00, e}, "scroll active");
  endtask
  task at_line(input [7:0] y, input e);
    for (k = 0; k < 1000 && line !== y; k = k + 1) @(negedge i_ref_clk);
    check(line, y, "line reached");
    check({7'h00, shown}, {7'h00, e}, "line shown");
  endtask
  // fetch line is start + ((y - start + step) mod (count + 1)) inside the window
  task fetch_at(input [7:0] y, input [7:0] e);
    for (k = 0; k < 1000 && line !== y; k = k + 1) @(negedge i_ref_clk);
    check(line, y, "line reached");
    check(fetch, e, "fetch line");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    flags(8'h0d, "reset flags");
    check({5'h00, greg, preg, dcdc}, 8'h00, "reset power");
    rd_chk(7'h0f, 8'h00);
    for (k = 0; k < 1000 && fs !== 1'b1; k = k + 1) @(negedge i_ref_clk);
    check({7'h00, fs}, 8'h01, "frame start seen");
    check(line, 8'haf, "frame start on last line");
    @(negedge i_ref_clk);
    check({7'h00, fs}, 8'h00, "frame start pulse");
    check(line, 8'h00, "scan wraps to top");
    $display("test reset done");
  endtask
  task t_regs;
    sps_host_model_inst.wr_reg(7'h0f, 8'h2c);
    sps_host_model_inst.wr_reg(7'h10, 8'haf);
    sps_host_model_inst.wr_reg(7'h7e, 8'ha5);
    rd_chk(7'h0f, 8'h2c);
    rd_chk(7'h10, 8'haf);
    rd_chk(7'h7e, 8'ha5);
    $display("test registers done");
  endtask
  task t_scroll;
    scroll(8'h2c, 8'h58, 8'h01, 1'b1);
    fetch_at(8'h2c, 8'h2d);
    fetch_at(8'h84, 8'h2c);
    fetch_at(8'h2b, 8'h2b);
    scroll(8'h2c, 8'h58, 8'h58, 1'b1);
    scroll(8'h2c, 8'h58, 8'h59, 1'b0);
    scroll(8'h2c, 8'h58, 8'h00, 1'b0);
    scroll(8'h58, 8'h57, 8'h02, 1'b1);
    scroll(8'h58, 8'h58, 8'h02, 1'b0);
    scroll(8'h00, 8'haf, 8'haf, 1'b1);
    scroll(8'h01, 8'haf, 8'h01, 1'b0);
    $display("test scroll done");
  endtask
  task t_partial;
    scroll(8'h2c, 8'h58, 8'h01, 1'b1);
    sps_host_model_inst.wr_reg(7'h14, 8'h00);
    sps_host_model_inst.wr_reg(7'h16, 8'h58);
    sps_host_model_inst.wr_reg(7'h15, 8'ha0);
    sps_host_model_inst.wr_reg(7'h17, 8'h10);
    sps_host_model_inst.wr_reg(7'h00, 8'h10);
    repeat (4) @(negedge i_ref_clk);
    check({7'h00, scr}, 8'h00, "partial stops scroll");
    at_line(8'h57, 1'b1);
    at_line(8'h58, 1'b0);
    at_line(8'h9f, 1'b0);
    at_line(8'ha0, 1'b1);
    sps_host_model_inst.wr_reg(7'h14, 8'h84);
    at_line(8'h83, 1'b0);
    at_line(8'h84, 1'b1);
    sps_host_model_inst.wr_reg(7'h00, 8'hc6);
    repeat (4) @(negedge i_ref_clk);
    check({ones, zeros, vss, col, lowp, scr, 2'b00}, 8'hdc, "control bits");
    $display("test partial done");
  endtask
  task t_standby;
    sps_host_model_inst.wr_reg(7'h11, 8'h00);
    sps_host_model_inst.pwr(8'h07);
    check({5'h00, greg, preg, dcdc}, 8'h07, "power on");
    // request early in a frame so the finishing scan is plainly visible
    for (k = 0; k < 1000 && line !== 8'h10; k = k + 1) @(negedge i_ref_clk);
    sps_host_model_inst.wr_reg(7'h00, 8'h08);
    repeat (3) @(negedge i_ref_clk);
    flags(8'h2d, "frame finish");
    for (k = 0; k < 2000 && gates !== 1'b1; k = k + 1) @(negedge i_ref_clk);
    check({7'h00, amp}, 8'h00, "discharge amps");
    check(line, 8'haf, "frame finished first");
    for (k = 0; k < 100 && done !== 1'b1; k = k + 1) @(negedge i_ref_clk);
    check({osc, amp, done, 5'h00}, 8'h20, "stopped");
    sps_host_model_inst.pwr_down;
    check({5'h00, greg, preg, dcdc}, 8'h00, "power off");
    sps_host_model_inst.pwr_up;
    check({5'h00, greg, preg, dcdc}, 8'h07, "power back");
    sps_host_model_inst.wr_reg(7'h00, 8'h00);
    repeat (3) @(negedge i_ref_clk);
    flags(8'h0d, "released");
    $display("test standby done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // whole run is a few thousand cycles
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    i_rst = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    t_reset;
    t_regs;
    t_scroll;
    t_partial;
    t_standby;
    wrap_up;
  end
endmodule // tb
